//--- logic/spi_memory_conversion_control.sv
// Purpose: Device end: byte memory over the serial link and the conversion flow.
// Assumes: Link pins are asynchronous and pass two flip-flops before use, SCK three.
// Notes:   Link and memory work on one clock; the rules carried out follow.
// Functional notes
// - Results readable at 0x010 to 0x05F.
// - Read: 0x03, address, then data returned.
// - Write: 0x02, address, data bytes stored.
// - Channel assignment words at 0x200 to 0x24F.
// - Writing 0x000 starts a conversion.
// - Instruction bit 1 clear means no-op.
// - Four-byte multi-channel mask at 0x0F4.
// - Mux settling delay byte at 0x0FF.
// - Custom table area 0x250 to 0x3CF.
// - 200 ms start-up, memory cleared.
// - After start-up: pin high, status 0x40.
// - Enter channel assignment state automatically.
// - Command value selects the conversion channel.
// - Conversion begins right after start command.
// - Converting: only status reads are served.
// - Conversion end: pin high, start clear, done set.
// - After conversion memory is accessible again.
// - Busy pin low during start-up and conversion.
// - Shift out on SCK fall, capture on rise.
// - Chip select frames; output off when high.
// - Reset held low; start-up after release.
`timescale 1ns/1ps
`default_nettype none
module spi_memory_conversion_control
  import spi_conv_pkg::*;
#(
  parameter int STARTUP_CYC = STARTUP_CYCLES,
  parameter int CONV_CYC    = CONV_CYCLES
) (
  input  wire logic              clk_i,
  input  wire logic              rst_n_i,
  input  wire logic              ce_i,
  spi_link_if.device             link,
  output logic                   converting_o,
  output logic [CHAN_W-1:0]      channel_o
);
  typedef enum logic [2:0] {
    ST_STARTUP, ST_READY, ST_SCAN, ST_SETTLE, ST_CONVERT, ST_STORE
  } conv_state_type;
  conv_state_type    state;
  logic [1:0]        cs_sync;
  logic [2:0]        sck_sync;
  logic [1:0]        sdi_sync;
  logic [2:0]        bit_cnt;
  logic [1:0]        byte_cnt;
  logic [7:0]        rx_sh;
  logic [7:0]        instr;
  logic [7:0]        tx_sh;
  logic [ADDR_W-1:0] addr;
  logic              cmd_wr;
  logic [7:0]        cmd_val;
  logic [7:0]        status;
  logic [31:0]       timer;
  logic [CHAN_W-1:0] chan;
  logic              multi;
  logic [1:0]        store_idx;
  logic [7:0]        mem [MEM_BYTES];

  logic              cs_s;
  logic              sck_rise;
  logic              sck_fall;
  logic [7:0]        next_byte;
  logic              byte_done;
  logic              is_write;
  logic              is_read;
  logic [ADDR_W-1:0] fetch_addr;
  logic [7:0]        fetch_val;
  logic              spi_we;
  logic              mem_we;
  logic [ADDR_W-1:0] mem_wa;
  logic [7:0]        mem_wd;
  logic [31:0]       mask;
  logic [31:0]       settle_lim;

  function automatic logic writable(input logic [ADDR_W-1:0] a);
    return a == ADDR_STATUS || a == ADDR_GLOBAL_CFG || a == ADDR_MUX_DELAY
           || (a >= MASK_FIRST && a <= MASK_LAST)
           || (a >= ASSIGN_FIRST && a <= ASSIGN_LAST)
           || (a >= CUSTOM_FIRST && a <= CUSTOM_LAST);
  endfunction

  assign cs_s      = cs_sync[1];
  assign sck_rise  = sck_sync[1] & ~sck_sync[2];
  assign sck_fall  = ~sck_sync[1] & sck_sync[2];
  assign next_byte = {rx_sh[6:0], sdi_sync[1]};
  assign byte_done = sck_rise && !cs_s && bit_cnt == 3'd7;
  assign is_write  = instr[INSTR_ACCESS_BIT] && instr == INSTR_WRITE;
  assign is_read   = instr[INSTR_ACCESS_BIT] && instr == INSTR_READ;
  assign mask      = {mem[MASK_FIRST], mem[MASK_FIRST + 10'h001],
                      mem[MASK_FIRST + 10'h002], mem[MASK_LAST]};
  assign settle_lim = 32'(mem[ADDR_MUX_DELAY]) * 32'(SETTLE_STEP_CYCLES);

  // Three synchroniser stages on SCK so that its edges can be found.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cs_sync  <= 2'b11;
      sck_sync <= 3'b000;
      sdi_sync <= 2'b00;
    end else if (ce_i) begin
      cs_sync  <= {cs_sync[0], link.cs_n};
      sck_sync <= {sck_sync[1:0], link.sck};
      sdi_sync <= {sdi_sync[0], link.sdi};
    end
  end

  // Address of the byte to present next on a read.
  always_comb begin
    fetch_addr = (byte_cnt == 2'd2) ? {addr[ADDR_W-1:8], next_byte} : addr + 10'h001;
    fetch_val = 8'h00;
    if (fetch_addr == ADDR_STATUS) begin
      fetch_val = status;
    end else if (state == ST_READY
                 && (writable(fetch_addr)
                     || (fetch_addr >= RESULT_FIRST && fetch_addr <= RESULT_LAST))) begin
      fetch_val = mem[fetch_addr];
    end
  end

  assign spi_we = byte_done && byte_cnt == 2'd3 && is_write && state == ST_READY
                  && addr != ADDR_STATUS && writable(addr);

  // Frame decoder: instruction, two address bytes, then data bytes.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      bit_cnt  <= 3'd0;
      byte_cnt <= 2'd0;
      rx_sh    <= 8'h00;
      instr    <= 8'h00;
      tx_sh    <= 8'h00;
      addr     <= '0;
      cmd_wr   <= 1'b0;
      cmd_val  <= 8'h00;
      link.sdo_drv <= 1'b1;
      link.sdo_oe  <= 1'b0;
    end else if (ce_i) begin
      cmd_wr      <= 1'b0;
      link.sdo_oe <= !cs_s;
      if (cs_s) begin
        bit_cnt  <= 3'd0;
        byte_cnt <= 2'd0;
        tx_sh    <= 8'h00;
      end else if (sck_rise) begin
        rx_sh   <= next_byte;
        bit_cnt <= bit_cnt + 3'd1;
        if (bit_cnt == 3'd7) begin
          if (byte_cnt != 2'd3) begin
            byte_cnt <= byte_cnt + 2'd1;
          end
          unique case (byte_cnt)
            2'd0: instr <= next_byte;
            2'd1: addr[ADDR_W-1:8] <= next_byte[ADDR_W-9:0];
            2'd2: addr[7:0] <= next_byte;
            2'd3: begin
              addr <= addr + 10'h001;
              if (is_write && addr == ADDR_STATUS && state == ST_READY) begin
                cmd_wr  <= 1'b1;
                cmd_val <= next_byte;
              end
            end
          endcase
          if (byte_cnt[1] && is_read) begin
            tx_sh <= fetch_val;
          end
        end
      end else if (sck_fall) begin
        link.sdo_drv <= tx_sh[7];
        tx_sh        <= {tx_sh[6:0], 1'b0};
      end
    end
  end

  // Single write port: start-up clear, result store, then host writes.
  always_comb begin
    mem_we = 1'b0;
    mem_wa = addr;
    mem_wd = next_byte;
    if (state == ST_STARTUP && timer < 32'(MEM_BYTES)) begin
      mem_we = 1'b1;
      mem_wa = timer[ADDR_W-1:0];
      mem_wd = 8'h00;
    end else if (state == ST_STORE) begin
      mem_we = 1'b1;
      mem_wa = RESULT_FIRST + {3'b000, chan - 5'd1, store_idx};
      mem_wd = store_idx == 2'd0 ? RESULT_VALID : (store_idx == 2'd3 ? {3'b000, chan} : 8'h00);
    end else if (spi_we) begin
      mem_we = 1'b1;
    end
  end

  always_ff @(posedge clk_i) begin
    if (ce_i && mem_we) begin
      mem[mem_wa] <= mem_wd;
    end
  end

  // Conversion flow.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state          <= ST_STARTUP;
      timer          <= 32'd0;
      status         <= STATUS_INIT;
      chan           <= '0;
      multi          <= 1'b0;
      store_idx      <= 2'd0;
      link.busy_done <= 1'b0;
      converting_o   <= 1'b0;
      channel_o      <= '0;
    end else if (ce_i) begin
      timer <= timer + 32'd1;
      unique case (state)
        ST_STARTUP: begin
          if (timer == 32'(STARTUP_CYC - 1)) begin
            state          <= ST_READY;
            status         <= STATUS_READY;
            link.busy_done <= 1'b1;
          end
        end
        ST_READY: begin
          if (cmd_wr) begin
            status <= cmd_val;
            if (cmd_val[STATUS_START_BIT]) begin
              chan           <= cmd_val[CHAN_W-1:0] == '0 ? 5'd1 : cmd_val[CHAN_W-1:0];
              multi          <= cmd_val[CHAN_W-1:0] == '0;
              state          <= ST_SCAN;
              link.busy_done <= 1'b0;
              converting_o   <= 1'b1;
            end
          end
        end
        ST_SCAN: begin
          timer <= 32'd0;
          if (chan > 5'(NUM_CHANNELS)) begin
            state          <= ST_READY;
            status[STATUS_START_BIT] <= 1'b0;
            status[STATUS_DONE_BIT]  <= 1'b1;
            link.busy_done <= 1'b1;
            converting_o   <= 1'b0;
          end else if (!multi || mask[chan - 5'd1]) begin
            state     <= ST_SETTLE;
            channel_o <= chan;
          end else begin
            chan <= chan + 5'd1;
          end
        end
        ST_SETTLE: begin
          if (timer >= settle_lim) begin
            state <= ST_CONVERT;
            timer <= 32'd0;
          end
        end
        ST_CONVERT: begin
          if (timer == 32'(CONV_CYC - 1)) begin
            state     <= ST_STORE;
            store_idx <= 2'd0;
          end
        end
        ST_STORE: begin
          store_idx <= store_idx + 2'd1;
          if (store_idx == 2'd3) begin
            state <= ST_SCAN;
            chan  <= multi ? chan + 5'd1 : 5'(NUM_CHANNELS + 1);
          end
        end
      endcase
    end
  end
endmodule
`default_nettype wire

//--- logic/spi_conv_pkg.sv
// Purpose: Shared constants of the serial memory conversion controller and its host.
// Assumes: Clock of 50 MHz; byte addresses are 10 bits wide.
// Notes:   Host register offsets and conversion timing figures are local choices.
`default_nettype none
package spi_conv_pkg;
  localparam int              ADDR_W            = 10;
  localparam int              MEM_BYTES         = 1024;
  localparam int              CHAN_W            = 5;
  localparam int              NUM_CHANNELS      = 20;
  localparam logic [7:0]      INSTR_READ        = 8'h03;
  localparam logic [7:0]      INSTR_WRITE       = 8'h02;
  localparam int              INSTR_ACCESS_BIT  = 1;
  localparam logic [ADDR_W-1:0] ADDR_STATUS     = 10'h000;
  localparam logic [ADDR_W-1:0] RESULT_FIRST    = 10'h010;
  localparam logic [ADDR_W-1:0] RESULT_LAST     = 10'h05f;
  localparam logic [ADDR_W-1:0] ADDR_GLOBAL_CFG = 10'h0f0;
  localparam logic [ADDR_W-1:0] MASK_FIRST      = 10'h0f4;
  localparam logic [ADDR_W-1:0] MASK_LAST       = 10'h0f7;
  localparam logic [ADDR_W-1:0] ADDR_MUX_DELAY  = 10'h0ff;
  localparam logic [ADDR_W-1:0] ASSIGN_FIRST    = 10'h200;
  localparam logic [ADDR_W-1:0] ASSIGN_LAST     = 10'h24f;
  localparam logic [ADDR_W-1:0] CUSTOM_FIRST    = 10'h250;
  localparam logic [ADDR_W-1:0] CUSTOM_LAST     = 10'h3cf;
  localparam int              CUSTOM_BYTES      = 384;
  localparam int              STATUS_START_BIT  = 7;
  localparam int              STATUS_DONE_BIT   = 6;
  localparam logic [7:0]      STATUS_INIT       = 8'h80;
  localparam logic [7:0]      STATUS_READY      = 8'h40;
  localparam logic [7:0]      RESULT_VALID      = 8'h01;
  localparam int              CLK_HZ            = 50_000_000;
  localparam int              STARTUP_TIME_MS   = 200;
  localparam int              STARTUP_CYCLES    = STARTUP_TIME_MS * (CLK_HZ / 1000);
  localparam int              CONV_CYCLES       = 2000;
  localparam int              SETTLE_STEP_CYCLES = 8;
  localparam int              SCK_HALF_CYCLES   = 4;
  localparam int              FRAME_BITS        = 32;
  localparam logic [2:0]      HREG_CTRL         = 3'h0;
  localparam logic [2:0]      HREG_ADDR_LO      = 3'h1;
  localparam logic [2:0]      HREG_ADDR_HI      = 3'h2;
  localparam logic [2:0]      HREG_WDATA        = 3'h3;
  localparam logic [2:0]      HREG_RDATA        = 3'h4;
  localparam logic [2:0]      HREG_STATUS       = 3'h5;
endpackage
`default_nettype wire

//--- logic/spi_link_if.sv
// Purpose: Serial link between the conversion controller and its host.
// Assumes: The data output line is pulled high when nobody drives it.
// Notes:   The device modport drives the data output with its enable.
`timescale 1ns/1ps
`default_nettype none
interface spi_link_if;
  logic cs_n;
  logic sck;
  logic sdi;
  logic sdo_drv;
  logic sdo_oe;
  logic sdo;
  logic busy_done;

  // Resolved level of the data output line.
  assign sdo = sdo_oe ? sdo_drv : 1'b1;

  modport device (input cs_n, input sck, input sdi,
                  output sdo_drv, output sdo_oe, output busy_done);
  modport host   (output cs_n, output sck, output sdi,
                  input sdo, input busy_done);
endinterface
`default_nettype wire

//--- logic/spi_host_controller.sv
// Purpose: Host end: runs one four-byte read or write frame per order.
// Assumes: Orders come over a plain register port on the same clock.
// Notes:   SCK is divided from clk_i; the data input is sampled before each fall.
`timescale 1ns/1ps
`default_nettype none
module spi_host_controller
  import spi_conv_pkg::*;
#(
  parameter int SCK_HALF = SCK_HALF_CYCLES
) (
  input  wire logic        clk_i,
  input  wire logic        rst_n_i,
  input  wire logic        ce_i,
  spi_link_if.host         link,
  input  wire logic [2:0]  reg_addr_i,
  input  wire logic [7:0]  reg_wdata_i,
  input  wire logic        reg_we_i,
  input  wire logic        reg_re_i,
  output logic [7:0]       reg_rdata_o
);
  typedef enum logic [1:0] {H_IDLE, H_RUN, H_GAP} host_state_type;

  host_state_type state;
  logic [7:0]     addr_lo;
  logic [1:0]     addr_hi;
  logic [7:0]     wdata;
  logic [7:0]     rdata;
  logic           do_write;
  logic [1:0]     sdo_sync;
  logic [1:0]     bd_sync;
  logic [31:0]    shift;
  logic [7:0]     rx;
  logic [4:0]     bit_cnt;
  logic [7:0]     div_cnt;
  logic           half_tick;

  assign half_tick = div_cnt == 8'(SCK_HALF - 1);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sdo_sync <= 2'b11;
      bd_sync  <= 2'b00;
    end else if (ce_i) begin
      sdo_sync <= {sdo_sync[0], link.sdo};
      bd_sync  <= {bd_sync[0], link.busy_done};
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      addr_lo     <= 8'h00;
      addr_hi     <= 2'b00;
      wdata       <= 8'h00;
      reg_rdata_o <= 8'h00;
    end else if (ce_i) begin
      if (reg_we_i && state == H_IDLE) begin
        unique case (reg_addr_i)
          HREG_ADDR_LO: addr_lo <= reg_wdata_i;
          HREG_ADDR_HI: addr_hi <= reg_wdata_i[1:0];
          HREG_WDATA:   wdata   <= reg_wdata_i;
          default:      ;
        endcase
      end
      if (reg_re_i) begin
        unique case (reg_addr_i)
          HREG_ADDR_LO: reg_rdata_o <= addr_lo;
          HREG_ADDR_HI: reg_rdata_o <= {6'h00, addr_hi};
          HREG_WDATA:   reg_rdata_o <= wdata;
          HREG_RDATA:   reg_rdata_o <= rdata;
          HREG_STATUS:  reg_rdata_o <= {6'h00, bd_sync[1], state != H_IDLE};
          default:      reg_rdata_o <= 8'h00;
        endcase
      end
    end
  end

  // Frame engine: chip select low, 32 SCK periods, chip select high, gap.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      state     <= H_IDLE;
      do_write  <= 1'b0;
      shift     <= 32'h0000_0000;
      rx        <= 8'h00;
      rdata     <= 8'h00;
      bit_cnt   <= 5'd0;
      div_cnt   <= 8'h00;
      link.cs_n <= 1'b1;
      link.sck  <= 1'b0;
      link.sdi  <= 1'b0;
    end else if (ce_i) begin
      div_cnt <= half_tick ? 8'h00 : div_cnt + 8'h01;
      unique case (state)
        H_IDLE: begin
          div_cnt <= 8'h00;
          if (reg_we_i && reg_addr_i == HREG_CTRL) begin
            do_write  <= reg_wdata_i[0];
            // Control bit 1 sends an instruction with the access bit clear.
            shift     <= {reg_wdata_i[1] ? 8'h01
                          : (reg_wdata_i[0] ? INSTR_WRITE : INSTR_READ),
                          6'h00, addr_hi, addr_lo, wdata};
            link.sdi  <= 1'b0;
            link.cs_n <= 1'b0;
            bit_cnt   <= 5'd0;
            state     <= H_RUN;
          end
        end
        H_RUN: begin
          if (bit_cnt == 5'd0 && div_cnt == 8'h00 && !link.sck) begin
            link.sdi <= shift[31];
          end
          if (half_tick) begin
            if (!link.sck) begin
              link.sck <= 1'b1;
            end else begin
              link.sck <= 1'b0;
              rx       <= {rx[6:0], sdo_sync[1]};
              shift    <= {shift[30:0], 1'b0};
              link.sdi <= shift[30];
              bit_cnt  <= bit_cnt + 5'd1;
              if (bit_cnt == 5'(FRAME_BITS - 1)) begin
                link.cs_n <= 1'b1;
                state     <= H_GAP;
              end
            end
          end
        end
        H_GAP: begin
          if (half_tick && bit_cnt != 5'd0) begin
            state <= H_IDLE;
            if (!do_write) begin
              rdata <= rx;
            end
          end else if (half_tick) begin
            bit_cnt <= 5'd1;
          end
        end
        default: state <= H_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

//--- dv/spi_link_sva.sv
// Purpose: Assertions on the serial link between the host and device ends.
// Assumes: Host divider at its default of four clocks per sck half period.
// Notes:   Sees only the interface signals, clock and reset.
`timescale 1ns/1ps
`default_nettype none
module spi_link_sva
  import spi_conv_pkg::*;
(
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n,
  input wire logic sck,
  input wire logic sdi,
  input wire logic sdo_drv,
  input wire logic sdo_oe,
  input wire logic sdo,
  input wire logic busy_done
);
  logic [5:0] rise_cnt;
  logic       sck_q;

  default clocking @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sck_q <= 1'b0;
    end else begin
      sck_q <= sck;
    end
  end

  // Counts sck rises inside a frame.
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      rise_cnt <= 6'h00;
    end else if (cs_n) begin
      rise_cnt <= 6'h00;
    end else if (sck && !sck_q) begin
      rise_cnt <= rise_cnt + 6'h01;
    end
  end

  sequence frame_end_s;
    $rose(cs_n);
  endsequence
  sequence frame_gap_s;
    cs_n [*8];
  endsequence

  oe_off_cs_a: assert property (cs_n [*5] |-> !sdo_oe)
    else $error("data output driven outside a frame");
  oe_on_cs_a: assert property (!cs_n [*5] |-> sdo_oe)
    else $error("data output not driven inside a frame");
  sdo_pull_a: assert property (!sdo_oe |-> sdo)
    else $error("released data line not high");
  start_busy_a: assert property ($rose(rst_n_i) |-> !busy_done [*8])
    else $error("busy pin high right after reset release");
  sdo_hold_a: assert property (sck && $past(sck) && sdo_oe && $past(sdo_oe) |-> $stable(sdo_drv))
    else $error("device data changed while sck high");
  sdi_hold_a: assert property (sck && $past(sck) |-> $stable(sdi))
    else $error("host data changed while sck high");
  cs_edge_a: assert property ($changed(cs_n) |-> !sck)
    else $error("chip select moved while sck high");
  sck_idle_a: assert property (cs_n && $past(cs_n) |-> !sck)
    else $error("sck active outside a frame");
  frame_gap_a: assert property (frame_end_s |-> frame_gap_s)
    else $error("gap between frames too short");
  frame_bits_a: assert property (frame_end_s |-> rise_cnt == 6'h20)
    else $error("frame bit count wrong");
endmodule
`default_nettype wire

//--- dv/test_spi_memory_conversion_control.sv
// Purpose: Host controller and device joined over the link, driven through host registers.
// Assumes: Start-up shortened to 2000 cycles and conversion to 1000 cycles.
// Notes:   Expected values follow the memory map and conversion flow.
`timescale 1ns/1ps
`default_nettype none
module test_spi_memory_conversion_control;
  import spi_conv_pkg::*;
  logic              clk_i;
  logic              rst_n_i;
  logic [2:0]        reg_addr;
  logic [7:0]        reg_wdata;
  logic              reg_we;
  logic              reg_re;
  logic [7:0]        reg_rdata;
  logic              converting;
  logic [CHAN_W-1:0] channel;
  logic [7:0]        rd;
  int                miscompares;
  int                compares;
  int                cnt;
  logic [ADDR_W-1:0] addrs [12] = '{10'h200, 10'h24f, 10'h250, 10'h3cf, 10'h0f0, 10'h0f4,
                                    10'h0f7, 10'h0ff, 10'h001, 10'h060, 10'h3d0, 10'h010};

  spi_link_if link ();

  spi_memory_conversion_control #(.STARTUP_CYC(2000), .CONV_CYC(1000))
    i_spi_memory_conversion_control (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .link(link), .converting_o(converting), .channel_o(channel));

  spi_host_controller i_spi_host_controller (.clk_i(clk_i), .rst_n_i(rst_n_i), .ce_i(1'b1),
    .link(link), .reg_addr_i(reg_addr), .reg_wdata_i(reg_wdata), .reg_we_i(reg_we),
    .reg_re_i(reg_re), .reg_rdata_o(reg_rdata));

  spi_link_sva i_spi_link_sva (.clk_i(clk_i), .rst_n_i(rst_n_i), .cs_n(link.cs_n),
    .sck(link.sck), .sdi(link.sdi), .sdo_drv(link.sdo_drv), .sdo_oe(link.sdo_oe),
    .sdo(link.sdo), .busy_done(link.busy_done));

  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    compares++;
    if (seen !== exp) begin
      miscompares++;
      $display("Error at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic close_out();
    if (miscompares == 0 && compares > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  task automatic give_up();
    miscompares++;
    close_out();
  endtask

  task automatic reg_wr(input logic [2:0] a, input logic [7:0] d);
    @(posedge clk_i);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk_i);
    reg_we    <= 1'b0;
  endtask

  task automatic reg_rd(input logic [2:0] a);
    @(posedge clk_i);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk_i);
    reg_re   <= 1'b0;
    #1;
    rd = reg_rdata;
  endtask

  // Polls the host status until its frame engine is idle again.
  task automatic wait_idle();
    int n;
    n = 0;
    rd = 8'h01;
    while (rd[0] !== 1'b0) begin
      reg_rd(HREG_STATUS);
      n++;
      if (n > 400) give_up();
    end
  endtask

  // One four-byte frame; read data lands in rd.
  task automatic mem_op(input logic [ADDR_W-1:0] a, input logic [7:0] d, input logic w);
    reg_wr(HREG_ADDR_LO, a[7:0]);
    reg_wr(HREG_ADDR_HI, {6'h00, a[9:8]});
    reg_wr(HREG_WDATA, d);
    reg_wr(HREG_CTRL, {7'h00, w});
    wait_idle();
    if (!w) reg_rd(HREG_RDATA);
  endtask

  task automatic rd_chk(input logic [ADDR_W-1:0] a, input logic [7:0] exp);
    mem_op(a, 8'h00, 1'b0);
    check(rd, exp);
  endtask

  task automatic wait_busy(input logic lvl, input int limit);
    cnt = 0;
    while (link.busy_done !== lvl) begin
      @(posedge clk_i);
      #1;
      cnt++;
      if (cnt > limit) give_up();
    end
  endtask

  initial begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end

  initial begin
    rst_n_i     = 1'b0;
    reg_addr    = 3'h0;
    reg_wdata   = 8'h00;
    reg_we      = 1'b0;
    reg_re      = 1'b0;
    miscompares = 0;
    compares    = 0;
    repeat (5) @(posedge clk_i);
    rst_n_i <= 1'b1;
    #1;
    check({7'h00, link.busy_done}, 8'h00);
    wait_busy(1'b1, 3000);
    check(8'((cnt >= 1995) && (cnt <= 2010)), 8'h01);
    rd_chk(ADDR_STATUS, 8'h40);
    reg_rd(HREG_STATUS);
    check(rd, 8'h02);
    foreach (addrs[i]) mem_op(addrs[i], addrs[i][7:0] ^ 8'h5a, 1'b1);
    foreach (addrs[i]) begin
      rd_chk(addrs[i], (i < 8) ? (addrs[i][7:0] ^ 8'h5a) : 8'h00);
    end
    mem_op(ADDR_STATUS, 8'h83, 1'b1);
    wait_busy(1'b0, 20);
    check({3'h0, channel}, 8'h03);
    check({7'h00, converting}, 8'h01);
    rd_chk(ADDR_STATUS, 8'h83);
    rd_chk(10'h200, 8'h00);
    mem_op(10'h204, 8'h11, 1'b1);
    wait_busy(1'b1, 4000);
    check({7'h00, converting}, 8'h00);
    rd_chk(ADDR_STATUS, 8'h43);
    rd_chk(10'h018, 8'h01);
    rd_chk(10'h01b, 8'h03);
    rd_chk(10'h204, 8'h00);
    rd_chk(10'h200, 8'h5a);
    reg_rd(HREG_ADDR_HI);
    check(rd, 8'h02);
    reg_wr(HREG_WDATA, 8'h77);
    reg_wr(HREG_CTRL, 8'h03);
    wait_idle();
    rd_chk(10'h200, 8'h5a);
    for (int a = 32'h0000_00f4; a < 32'h0000_00f7; a++) mem_op(ADDR_W'(a), 8'h00, 1'b1);
    mem_op(MASK_LAST, 8'h03, 1'b1);
    mem_op(ADDR_STATUS, 8'h80, 1'b1);
    wait_busy(1'b0, 20);
    wait_busy(1'b1, 6000);
    rd_chk(10'h013, 8'h01);
    rd_chk(10'h017, 8'h02);
    rd_chk(ADDR_STATUS, 8'h40);
    @(posedge clk_i);
    rst_n_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    check({7'h00, link.busy_done}, 8'h00);
    rst_n_i <= 1'b1;
    wait_busy(1'b1, 3000);
    rd_chk(10'h200, 8'h00);
    close_out();
  end
endmodule
`default_nettype wire
